// File: port_block_defines.vh
// Address map, field positions and reset values of the general-purpose port block
`ifndef PORT_BLOCK_DEFINES_VH
`define PORT_BLOCK_DEFINES_VH

// Data-memory port window inside every bank
`define PORT_ADDR_A        7'h70
`define PORT_ADDR_B        7'h71
`define PORT_ADDR_C        7'h72
`define PORT_ADDR_D        7'h73

// Bank-pair select bit inside the 2-bit bank number
`define BANK_PAIR_BIT      0

// Register-file addresses of the direction select registers
`define RF_GROUP_DIR       7'h27
`define RF_PORT_2A_DIR     7'h34
`define RF_PORT_1B_DIR     7'h35
`define RF_PORT_0B_DIR     7'h36
`define RF_PORT_0A_DIR     7'h37

// Direction value after any reset: all input
`define DIR_RESET          4'h0
// Group direction lives in bit 0 of its select register
`define GROUP_DIR_BIT      0
// Output latch value after power-on (undefined in silicon, zero here)
`define LATCH_POWER_ON     4'h0
// Value returned for unmapped reads
`define READ_NONE          4'h0

`endif

// File: port_latch_bank.v
// Set of 4-bit output latches cleared only by power-on reset
`timescale 1ns/100ps
`default_nettype none
`include "port_block_defines.vh"

module port_latch_bank #(
  parameter COUNT = 10
) (
  input  wire                 clk,
  input  wire                 porRst_n,
  input  wire                 writeEnable,
  input  wire [3:0]           writeIndex,
  input  wire [3:0]           writeData,
  output wire [COUNT*4-1:0]   latchFlat
);

  // ****************************************************************
  // Latch storage
  // ****************************************************************
  reg  [3:0]  latch [0:COUNT-1];  // One latch word per port
  integer     i;                  // Loop index

  // Only power-on clears; a CE reset leaves contents held
  always @(posedge clk or negedge porRst_n) begin
    if (!porRst_n) begin
      for (i = 0; i < COUNT; i = i + 1) begin
        latch[i] <= `LATCH_POWER_ON;
      end
    end else if (writeEnable) begin
      latch[writeIndex] <= writeData;
    end
  end

  // Flatten for the top module
  genvar g;
  generate
    for (g = 0; g < COUNT; g = g + 1) begin : flat
      assign latchFlat[g*4 +: 4] = latch[g];
    end
  endgenerate

endmodule // port_latch_bank
`default_nettype wire

// File: banked_general_purpose_ports.v
// General-purpose port block: banked port registers, direction selects, pins
//
// What this block does
// - Port registers sit at 70H to 73H
// - Banks 1/3 alias port sets; banks 0/2 share only 73H
// - Ports are bidirectional, input-only, output-only
// - Bit ports choose direction per pin
// - Group port switches all pins together
// - Output pin drives latch bit value
// - Input pin read returns pin level
// - Each bidirectional port has own direction register
// - Pins are plain ports after power-on
// - Any data-memory instruction reaches port registers
// - Selects for 0A,0B,1B at 37H,36H,35H
// - Group select 27H, port 2A select 34H
// - Bidirectional data register address decode
// - Input port read at 73H bank 0/2
// - Output-only data register address decode
// - Reset forces input; CE reset keeps latches
// - Write to input pin updates latch only
// - Output pin read returns latch value
// - Writes to input-only port do nothing
`timescale 1ns/100ps
`default_nettype none
`include "port_block_defines.vh"

module banked_general_purpose_ports (
  input  wire        clk,
  input  wire        porRst_n,
  input  wire        ceRst_n,
  input  wire [1:0]  dmBank,
  input  wire [6:0]  dmAddr,
  input  wire        dmWrite,
  input  wire        dmRead,
  input  wire [3:0]  dmWriteData,
  output reg  [3:0]  dmReadData,
  output wire        dmHit,
  input  wire [6:0]  rfAddr,
  input  wire        rfWrite,
  input  wire [3:0]  rfWriteData,
  output reg  [3:0]  rfReadData,
  output wire        rfHit,
  input  wire [3:0]  bidirPortZeroAIn,
  output wire [3:0]  bidirPortZeroAOut,
  output wire [3:0]  bidirPortZeroAOe,
  input  wire [3:0]  bidirPortZeroBIn,
  output wire [3:0]  bidirPortZeroBOut,
  output wire [3:0]  bidirPortZeroBOe,
  input  wire [3:0]  bidirPortOneBIn,
  output wire [3:0]  bidirPortOneBOut,
  output wire [3:0]  bidirPortOneBOe,
  input  wire [3:0]  groupPortOneCIn,
  output wire [3:0]  groupPortOneCOut,
  output wire [3:0]  groupPortOneCOe,
  input  wire [3:0]  bidirPortTwoAIn,
  output wire [3:0]  bidirPortTwoAOut,
  output wire [3:0]  bidirPortTwoAOe,
  input  wire [3:0]  inputPortZeroD,
  output wire [3:0]  outputPortZeroC,
  output wire [3:0]  outputPortOneA,
  output wire [3:0]  outputPortOneD,
  output wire [3:0]  outputPortTwoB,
  output wire [3:0]  outputPortTwoC
);

  // ****************************************************************
  // Latch indices
  // ****************************************************************
  // Each writable port register owns one latch word; the index
  // doubles as the select into the flattened latch bus
  localparam [3:0] L_0A = 4'h0;  // Bidirectional 0A
  localparam [3:0] L_0B = 4'h1;  // Bidirectional 0B
  localparam [3:0] L_0C = 4'h2;  // Output 0C
  localparam [3:0] L_1A = 4'h3;  // Output 1A
  localparam [3:0] L_1B = 4'h4;  // Bidirectional 1B
  localparam [3:0] L_1C = 4'h5;  // Group 1C
  localparam [3:0] L_1D = 4'h6;  // Output 1D
  localparam [3:0] L_2A = 4'h7;  // Bidirectional 2A
  localparam [3:0] L_2B = 4'h8;  // Output 2B
  localparam [3:0] L_2C = 4'h9;  // Output 2C
  localparam [3:0] L_NONE = 4'hf; // No latch (input-only or unmapped)

  // ****************************************************************
  // Reset and pin synchronisers
  // ****************************************************************
  // Direction registers follow both resets; latches and read
  // registers follow power-on only, so a CE reset keeps pin data
  wire        anyRst_n = porRst_n & ceRst_n;  // Either reset clears direction
  reg  [19:0] pinMeta;                         // First stage, read only by second
  reg  [19:0] pinSync;                         // Second stage, used by logic
  reg  [3:0]  inDMeta;                         // Input-only port first stage
  reg  [3:0]  inDSync;                         // Input-only port second stage

  // Pin levels are asynchronous to clk, hence two stages before use
  // Two-flop sampling of every external pin level
  always @(posedge clk or negedge porRst_n) begin
    if (!porRst_n) begin
      pinMeta <= 20'h0_0000;
      pinSync <= 20'h0_0000;
      inDMeta <= 4'h0;
      inDSync <= 4'h0;
    end else begin
      pinMeta <= {bidirPortTwoAIn, groupPortOneCIn, bidirPortOneBIn, bidirPortZeroBIn, bidirPortZeroAIn};
      pinSync <= pinMeta;
      inDMeta <= inputPortZeroD;
      inDSync <= inDMeta;
    end
  end

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // Map bank pair and port address to a latch index
  function [3:0] decodeLatch;
    input       pairOdd;
    input [6:0] addr;
    begin
      case ({pairOdd, addr})
        {1'h0, `PORT_ADDR_A}: decodeLatch = L_0A;  // Bank 0; bank 2 overrides
        {1'h0, `PORT_ADDR_B}: decodeLatch = L_0B;
        {1'h0, `PORT_ADDR_C}: decodeLatch = L_0C;
        {1'h1, `PORT_ADDR_A}: decodeLatch = L_1A;
        {1'h1, `PORT_ADDR_B}: decodeLatch = L_1B;
        {1'h1, `PORT_ADDR_C}: decodeLatch = L_1C;
        {1'h1, `PORT_ADDR_D}: decodeLatch = L_1D;
        default:              decodeLatch = L_NONE;
      endcase
    end
  endfunction

  // Banks 0 and 2 differ in their 70H-72H ports; bank 1 and 3 fully alias
  function [3:0] decodeBank;
    input [1:0] bank;
    input [6:0] addr;
    reg   [3:0] base;
    begin
      base = decodeLatch(bank[`BANK_PAIR_BIT], addr);
      if (bank == 2'h2) begin
        case (addr)
          `PORT_ADDR_A: decodeBank = L_2A;
          `PORT_ADDR_B: decodeBank = L_2B;
          `PORT_ADDR_C: decodeBank = L_2C;
          default:      decodeBank = base;
        endcase
      end else begin
        decodeBank = base;
      end
    end
  endfunction

  // Decoded port of the current data-memory access; L_NONE for
  // the input-only register and for addresses outside the window
  wire [3:0] dmIndex = decodeBank(dmBank, dmAddr);
  wire       isInD   = (dmAddr == `PORT_ADDR_D) && !dmBank[`BANK_PAIR_BIT];
  assign dmHit = (dmIndex != L_NONE) || isInD;

  // ****************************************************************
  // Direction select registers
  // ****************************************************************
  reg  [3:0] dir0A;     // 0A per-pin direction
  reg  [3:0] dir0B;     // 0B per-pin direction
  reg  [3:0] dir1B;     // 1B per-pin direction
  reg  [3:0] dirGroup;  // 1C group direction
  reg  [3:0] dir2A;     // 2A per-pin direction

  // Any reset returns all bidirectional ports to input
  always @(posedge clk or negedge anyRst_n) begin
    if (!anyRst_n) begin
      dir0A    <= `DIR_RESET;
      dir0B    <= `DIR_RESET;
      dir1B    <= `DIR_RESET;
      dirGroup <= `DIR_RESET;
      dir2A    <= `DIR_RESET;
    end else if (rfWrite) begin
      case (rfAddr)
        `RF_PORT_0A_DIR: dir0A    <= rfWriteData;
        `RF_PORT_0B_DIR: dir0B    <= rfWriteData;
        `RF_PORT_1B_DIR: dir1B    <= rfWriteData;
        `RF_GROUP_DIR:   dirGroup <= {3'h0, rfWriteData[`GROUP_DIR_BIT]};
        `RF_PORT_2A_DIR: dir2A    <= rfWriteData;
        default: ;                                 // Other register-file cells
      endcase
    end
  end

  // Register-file hit flag for the CPU side, purely combinational
  assign rfHit = (rfAddr == `RF_PORT_0A_DIR) || (rfAddr == `RF_PORT_0B_DIR) ||
                 (rfAddr == `RF_PORT_1B_DIR) || (rfAddr == `RF_GROUP_DIR) ||
                 (rfAddr == `RF_PORT_2A_DIR);

  // Register-file read path, registered
  always @(posedge clk or negedge porRst_n) begin
    if (!porRst_n) begin
      rfReadData <= `READ_NONE;
    end else begin
      case (rfAddr)
        `RF_PORT_0A_DIR: rfReadData <= dir0A;
        `RF_PORT_0B_DIR: rfReadData <= dir0B;
        `RF_PORT_1B_DIR: rfReadData <= dir1B;
        `RF_GROUP_DIR:   rfReadData <= dirGroup;
        `RF_PORT_2A_DIR: rfReadData <= dir2A;
        default:         rfReadData <= `READ_NONE;
      endcase
    end
  end

  // ****************************************************************
  // Output latches
  // ****************************************************************
  wire [39:0] latchFlat;  // Ten latch words
  // Input-only port has no latch, so its writes vanish
  wire        latchWrite = dmWrite && (dmIndex != L_NONE);

  // Power-on only reset keeps latch contents over a CE reset
  port_latch_bank #(
    .COUNT(10)
  ) i_port_latch_bank (
    .clk         (clk),
    .porRst_n    (porRst_n),
    .writeEnable (latchWrite),
    .writeIndex  (dmIndex),
    .writeData   (dmWriteData),
    .latchFlat   (latchFlat)
  );

  // Pick one latch word
  function [3:0] latchOf;
    input [39:0] flat;
    input [3:0]  idx;
    begin
      latchOf = flat[idx*4 +: 4];
    end
  endfunction

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  wire [3:0] oe1C = {4{dirGroup[`GROUP_DIR_BIT]}};

  // Enable high drives the latch value onto the pin; one means output
  assign bidirPortZeroAOe  = dir0A;
  assign bidirPortZeroBOe  = dir0B;
  assign bidirPortOneBOe   = dir1B;
  assign groupPortOneCOe   = oe1C;
  assign bidirPortTwoAOe   = dir2A;
  // Latch words drive the pins; enables decide whether they reach them
  assign bidirPortZeroAOut = latchOf(latchFlat, L_0A);
  assign bidirPortZeroBOut = latchOf(latchFlat, L_0B);
  assign bidirPortOneBOut  = latchOf(latchFlat, L_1B);
  assign groupPortOneCOut  = latchOf(latchFlat, L_1C);
  assign bidirPortTwoAOut  = latchOf(latchFlat, L_2A);
  // Output-only ports always show their latch
  assign outputPortZeroC   = latchOf(latchFlat, L_0C);
  assign outputPortOneA    = latchOf(latchFlat, L_1A);
  assign outputPortOneD    = latchOf(latchFlat, L_1D);
  assign outputPortTwoB    = latchOf(latchFlat, L_2B);
  assign outputPortTwoC    = latchOf(latchFlat, L_2C);

  // Per pin: latch when output, synchronised pin when input
  function [3:0] mixRead;
    input [3:0] dir;
    input [3:0] lat;
    input [3:0] pin;
    begin
      mixRead = (dir & lat) | (~dir & pin);
    end
  endfunction

  // ****************************************************************
  // Data-memory read path
  // ****************************************************************
  reg [3:0] next_dmReadData;  // Combinational read value

  always @* begin
    next_dmReadData = `READ_NONE;
    if (isInD) begin
      next_dmReadData = inDSync;
    end else begin
      case (dmIndex)
        L_0A: next_dmReadData = mixRead(dir0A, latchOf(latchFlat, L_0A), pinSync[3:0]);
        L_0B: next_dmReadData = mixRead(dir0B, latchOf(latchFlat, L_0B), pinSync[7:4]);
        L_1B: next_dmReadData = mixRead(dir1B, latchOf(latchFlat, L_1B), pinSync[11:8]);
        L_1C: next_dmReadData = mixRead(oe1C, latchOf(latchFlat, L_1C), pinSync[15:12]);
        L_2A: next_dmReadData = mixRead(dir2A, latchOf(latchFlat, L_2A), pinSync[19:16]);
        L_NONE: next_dmReadData = `READ_NONE;
        default: next_dmReadData = latchOf(latchFlat, dmIndex);
      endcase
    end
  end

  // Reading and writing in one cycle returns the old latch value,
  // since the latch only changes at that same edge
  // Read data held in a register, updated on each read strobe
  always @(posedge clk or negedge porRst_n) begin
    if (!porRst_n) begin
      dmReadData <= `READ_NONE;
    end else if (dmRead) begin
      dmReadData <= next_dmReadData;
    end
  end

endmodule // banked_general_purpose_ports
`default_nettype wire

// File: ext_pin_model.sv
// Outside circuit on one 4-bit bidirectional port
`timescale 1ns/100ps
`default_nettype none
module ext_pin_model (
  input  wire logic [3:0] drvOut,   // Level the block drives
  input  wire logic [3:0] drvOe,    // High where the block drives
  input  wire logic [3:0] extLevel, // Level the outside circuit applies
  output wire logic [3:0] pinLevel  // Resolved wire level
);
  // Block wins where it drives, outside circuit elsewhere
  assign pinLevel = (drvOut & drvOe) | (extLevel & ~drvOe);
endmodule // ext_pin_model
`default_nettype wire

// File: port_block_assertions.sv
// Concurrent checks on the port block ports
`timescale 1ns/100ps
`default_nettype none
module port_block_checker (
  input wire       clk,
  input wire       porRst_n,
  input wire       ceRst_n,
  input wire [1:0] dmBank,
  input wire [6:0] dmAddr,
  input wire       dmWrite,
  input wire       dmRead,
  input wire [3:0] dmWriteData,
  input wire [3:0] dmReadData,
  input wire       dmHit,
  input wire [6:0] rfAddr,
  input wire       rfWrite,
  input wire [3:0] rfWriteData,
  input wire       rfHit,
  input wire [3:0] bidirPortZeroAOe,
  input wire [3:0] groupPortOneCOe,
  input wire [3:0] outputPortZeroC,
  input wire [3:0] outputPortOneD
);
  // ****************************************
  // One clock domain, power-on reset disables
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!porRst_n);
  ce_oe_clear_a: assert property (!ceRst_n |-> bidirPortZeroAOe == 4'h0 && groupPortOneCOe == 4'h0)
    else $error("direction not cleared by reset");
  ce_latch_hold_a: assert property (!ceRst_n && !dmWrite |=> $stable(outputPortZeroC) && $stable(outputPortOneD))
    else $error("latch lost in reset");
  group_together_a: assert property (groupPortOneCOe == 4'h0 || groupPortOneCOe == 4'hF)
    else $error("group pins split");
  zero_c_write_a: assert property (dmWrite && ceRst_n && dmBank == 2'h0 && dmAddr == 7'h72
    |=> outputPortZeroC == $past(dmWriteData)) else $error("port 0C write lost");
  one_d_write_a: assert property (dmWrite && ceRst_n && dmBank[0] && dmAddr == 7'h73
    |=> outputPortOneD == $past(dmWriteData)) else $error("port 1D write lost");
  dir_write_a: assert property (rfWrite && ceRst_n && rfAddr == 7'h37
    |=> bidirPortZeroAOe == $past(rfWriteData)) else $error("port 0A direction wrong");
  dm_window_a: assert property (dmHit == (dmAddr >= 7'h70 && dmAddr <= 7'h73))
    else $error("port window decode wrong");
  rf_window_a: assert property (rfHit == (rfAddr == 7'h27 || (rfAddr >= 7'h34 && rfAddr <= 7'h37)))
    else $error("select decode wrong");
  latch_read_a: assert property (dmRead && dmBank == 2'h0 && dmAddr == 7'h72
    |=> dmReadData == $past(outputPortZeroC)) else $error("latch read wrong");
  // Main scenarios
  cover property (dmWrite && dmBank == 2'h3 && dmAddr == 7'h73);
  cover property (!ceRst_n);
  cover property (groupPortOneCOe == 4'hF);
endmodule // port_block_checker
bind banked_general_purpose_ports port_block_checker u_chk (
  .clk(clk), .porRst_n(porRst_n), .ceRst_n(ceRst_n), .dmBank(dmBank), .dmAddr(dmAddr),
  .dmWrite(dmWrite), .dmRead(dmRead), .dmWriteData(dmWriteData), .dmReadData(dmReadData),
  .dmHit(dmHit), .rfAddr(rfAddr), .rfWrite(rfWrite), .rfWriteData(rfWriteData), .rfHit(rfHit),
  .bidirPortZeroAOe(bidirPortZeroAOe), .groupPortOneCOe(groupPortOneCOe),
  .outputPortZeroC(outputPortZeroC), .outputPortOneD(outputPortOneD)
);
`default_nettype wire

// File: banked_general_purpose_ports_tb.sv
// Self-checking bench of the port block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin numErrors++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module banked_general_purpose_ports_tb;
  // ****************************************
  // Stimulus, wiring and tables
  // ****************************************
  logic       clk = 1'h0;
  logic       porRst_n = 1'h0;
  logic       ceRst_n = 1'h0;
  logic       dmWrite = 1'h0;
  logic       dmRead = 1'h0;
  logic       rfWrite = 1'h0;
  logic [1:0] dmBank = 2'h0;
  logic [6:0] dmAddr = 7'h00;
  logic [6:0] rfAddr = 7'h00;
  logic [3:0] dmWriteData = 4'h0;
  logic [3:0] rfWriteData = 4'h0;
  logic [3:0] extD = 4'h0;                    // Input-only pins
  logic [3:0] ext [0:4] = '{default: 4'h0};   // Outside levels, 0A 0B 1B 2A 1C
  wire  [3:0] dmReadData, rfReadData;
  wire        dmHit, rfHit;
  wire  [3:0] pOut [0:4], pOe [0:4], pin [0:4], oo [0:4];
  int         numErrors = 0;
  int         nCompared = 0;
  int         i;
  logic [1:0] b;
  logic [6:0] a, r;
  // Output-only ports 0C 1A 1D 2B 2C: bank, address
  logic [8:0] outTbl [0:4] = '{{2'h0, 7'h72}, {2'h1, 7'h70}, {2'h3, 7'h73}, {2'h2, 7'h71}, {2'h2, 7'h72}};
  // Bit ports 0A 0B 1B 2A: bank, address, select address
  logic [15:0] bitTbl [0:3] = '{{2'h0, 7'h70, 7'h37}, {2'h0, 7'h71, 7'h36}, {2'h1, 7'h71, 7'h35},
                                {2'h2, 7'h70, 7'h34}};
  banked_general_purpose_ports i_banked_general_purpose_ports (
    .clk(clk), .porRst_n(porRst_n), .ceRst_n(ceRst_n), .dmBank(dmBank), .dmAddr(dmAddr),
    .dmWrite(dmWrite), .dmRead(dmRead), .dmWriteData(dmWriteData), .dmReadData(dmReadData),
    .dmHit(dmHit), .rfAddr(rfAddr), .rfWrite(rfWrite), .rfWriteData(rfWriteData),
    .rfReadData(rfReadData), .rfHit(rfHit),
    .bidirPortZeroAIn(pin[0]), .bidirPortZeroAOut(pOut[0]), .bidirPortZeroAOe(pOe[0]),
    .bidirPortZeroBIn(pin[1]), .bidirPortZeroBOut(pOut[1]), .bidirPortZeroBOe(pOe[1]),
    .bidirPortOneBIn(pin[2]), .bidirPortOneBOut(pOut[2]), .bidirPortOneBOe(pOe[2]),
    .bidirPortTwoAIn(pin[3]), .bidirPortTwoAOut(pOut[3]), .bidirPortTwoAOe(pOe[3]),
    .groupPortOneCIn(pin[4]), .groupPortOneCOut(pOut[4]), .groupPortOneCOe(pOe[4]),
    .inputPortZeroD(extD), .outputPortZeroC(oo[0]), .outputPortOneA(oo[1]),
    .outputPortOneD(oo[2]), .outputPortTwoB(oo[3]), .outputPortTwoC(oo[4])
  );
  // Outside circuit on every bidirectional port
  for (genvar g = 0; g < 5; g++) begin : gPin
    ext_pin_model i_ext_pin_model (.drvOut(pOut[g]), .drvOe(pOe[g]), .extLevel(ext[g]), .pinLevel(pin[g]));
  end
  // 50 ns clock
  initial forever #25 clk = ~clk;
  // Data-memory write, one cycle strobe
  task dmw(input logic [1:0] bk, input logic [6:0] ad, input logic [3:0] dt);
    @(negedge clk);
    {dmBank, dmAddr, dmWriteData, dmWrite} = {bk, ad, dt, 1'h1};
    @(negedge clk);
    dmWrite = 1'h0;
  endtask
  // Data-memory read, answer one edge later
  task dmr(input logic [1:0] bk, input logic [6:0] ad, input logic [3:0] ex);
    @(negedge clk);
    {dmBank, dmAddr, dmRead} = {bk, ad, 1'h1};
    @(negedge clk);
    dmRead = 1'h0;
    `CHK("dmReadData", ex, dmReadData)
  endtask
  // Select register write
  task rfw(input logic [6:0] ad, input logic [3:0] dt);
    @(negedge clk);
    {rfAddr, rfWriteData, rfWrite} = {ad, dt, 1'h1};
    @(negedge clk);
    rfWrite = 1'h0;
  endtask
  // Select register read, shown after next edge
  task rfr(input logic [6:0] ad, input logic [3:0] ex);
    @(negedge clk);
    rfAddr = ad;
    @(negedge clk);
    `CHK("rfReadData", ex, rfReadData)
  endtask
  // Counts, verdict and end of run
  task giveVerdict;
    $display("compared %0d mismatches %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Hang guard
  initial begin
    #1000000;
    numErrors++;
    giveVerdict();
  end
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (10) @(negedge clk);
    porRst_n = 1'h1;
    ceRst_n = 1'h1;
    for (i = 0; i < 5; i++) begin
      `CHK("oe after reset", 4'h0, pOe[i])
      `CHK("latch after reset", 4'h0, oo[i])
    end
    $display("test reset done");
    for (i = 0; i < 5; i++) dmw(outTbl[i][8:7], outTbl[i][6:0], 4'(i + 1));
    for (i = 0; i < 5; i++) begin
      b = outTbl[i][8:7];
      dmr(b ^ {b[0], 1'h0}, outTbl[i][6:0], 4'(i + 1));
      `CHK("output pins", 4'(i + 1), oo[i])
    end
    $display("test output ports done");
    for (i = 0; i < 4; i++) begin
      {b, a, r} = bitTbl[i];
      ext[i] = 4'hA;
      rfw(r, 4'h3);
      dmw(b, a, 4'h5);
      repeat (3) @(negedge clk);
      dmr(b ^ {b[0], 1'h0}, a, 4'h9);
      `CHK("latch", 4'h5, pOut[i])
      `CHK("oe", 4'h3, pOe[i])
      `CHK("pin", 4'h9, pin[i])
      rfr(r, 4'h3);
      `CHK("rfHit", 1'h1, rfHit)
    end
    rfw(7'h27, 4'hF);
    rfr(7'h27, 4'h1);
    `CHK("group oe", 4'hF, pOe[4])
    dmw(2'h3, 7'h72, 4'h6);
    dmr(2'h1, 7'h72, 4'h6);
    ext[4] = 4'hC;
    rfw(7'h27, 4'hE);
    repeat (3) @(negedge clk);
    `CHK("group oe", 4'h0, pOe[4])
    dmr(2'h1, 7'h72, 4'hC);
    `CHK("group latch", 4'h6, pOut[4])
    $display("test directions done");
    extD = 4'h6;
    repeat (3) @(negedge clk);
    dmr(2'h0, 7'h73, 4'h6);
    dmw(2'h2, 7'h73, 4'hF);
    dmr(2'h2, 7'h73, 4'h6);
    `CHK("dmHit", 1'h1, dmHit)
    `CHK("port 0C", 4'h1, oo[0])
    dmr(2'h0, 7'h74, 4'h0);
    `CHK("dmHit", 1'h0, dmHit)
    rfr(7'h30, 4'h0);
    `CHK("rfHit", 1'h0, rfHit)
    $display("test input and unmapped done");
    ceRst_n = 1'h0;
    @(negedge clk);
    `CHK("oe in reset", 4'h0, pOe[0])
    ceRst_n = 1'h1;
    `CHK("latch kept", 4'h2, oo[1])
    `CHK("latch kept", 4'h5, pOut[0])
    rfr(7'h37, 4'h0);
    $display("test second reset done");
    giveVerdict();
  end
endmodule // banked_general_purpose_ports_tb
`default_nettype wire
